/* logic/lrp_consts.vh */
// Purpose: constants of the response packet builder
// Assumes: byte-wide link, 32-bit register port
// Notes:   offsets are byte addresses
`ifndef LRP_CONSTS_VH
`define LRP_CONSTS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define LRP_REG_CTRL        8'h00
`define LRP_REG_STATUS      8'h04
`define LRP_REG_LAST_HDR    8'h08
`define LRP_CTRL_RST        32'h0000_0000

// ----------------------------------------
// control fields
// ----------------------------------------
`define LRP_CTRL_SRCID_LSB  0
`define LRP_CTRL_HOST_BIT   8
`define LRP_CTRL_EN_BIT     9

// ----------------------------------------
// command codes and request kinds
// ----------------------------------------
`define LRP_CMD_READ_REPLY  6'h30
`define LRP_CMD_TGT_DONE    6'h33
`define LRP_KIND_DW_READ    2'h0
`define LRP_KIND_BYTE_READ  2'h1
`define LRP_KIND_RMW        2'h2
`define LRP_KIND_NO_DATA    2'h3
`define LRP_RMW_COUNT       4'h1
`define LRP_BYTE_COUNT      4'h0

// ----------------------------------------
// packet sizes
// ----------------------------------------
`define LRP_HDR_BYTES       7'h04
`define LRP_BUF_WORDS       16

`endif

/* logic/lrp_sync.v */
// Purpose: two-flop synchroniser with rising-edge pulse
// Assumes: input slower than half the system clock
// Notes:   first flop read only by the second
`timescale 1ns/1ps
module lrp_sync
(
  input  wire i_clk,    // system clock
  input  wire i_rst_n,  // sync reset, active low
  input  wire i_async,  // foreign level
  output reg  o_level,  // synchronised level
  output reg  o_rise    // one-cycle pulse on rising edge
);
  reg meta_q;
  reg sync_q;

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      o_level <= 1'b0;
      o_rise  <= 1'b0;
    end
    else
    begin
      meta_q  <= i_async;
      sync_q  <= meta_q;
      o_level <= sync_q;
      o_rise  <= sync_q & ~o_level;
    end
  end
endmodule // lrp_sync

/* logic/lrp_hdr.v */
// Purpose: assemble the four header bytes of a response
// Assumes: fields already chosen by the caller
// Notes:   reserved bits forced to zero
`timescale 1ns/1ps
`include "lrp_consts.vh"
module lrp_hdr
(
  input  wire        i_is_read,  // read reply, else completion
  input  wire        i_tc,       // time_critical_flag
  input  wire        i_pass,     // may_overtake_posted_flag
  input  wire        i_host,     // from_host_flag
  input  wire [4:0]  i_srcid,    // stream_source_id
  input  wire [4:0]  i_tag,      // request_tag
  input  wire        i_fail,     // failure_flag
  input  wire        i_nxa,      // nonexistent_address_flag
  input  wire [3:0]  i_len,      // payload_length_field
  output wire [31:0] o_hdr       // byte 0 in bits 7:0
);
  wire [5:0] cmd;
  wire [3:0] len;
  wire       nonexistent_address_flag;

  assign cmd = i_is_read ? `LRP_CMD_READ_REPLY : `LRP_CMD_TGT_DONE;
  // completion has no length field
  assign len = i_is_read ? i_len : 4'h0;
  // nxa is meaningless without failure, so never sent alone
  assign nonexistent_address_flag = i_fail & i_nxa;
  assign o_hdr[7:0]   = {i_tc, 1'b0, cmd};
  assign o_hdr[15:8]  = {i_pass, i_host, 1'b0, i_srcid};
  assign o_hdr[23:16] = {len[1:0], i_fail, i_tag};
  assign o_hdr[31:24] = {2'b00, nonexistent_address_flag, 3'b000, len[3:2]};
endmodule // lrp_hdr

/* logic/lrp_top.v */
// Purpose: builds and sends read replies and target completions
// Assumes: request side and data buffer driven on I_CLK_SYS
// Notes:   link clock sampled; one byte per link rising edge
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "lrp_consts.vh"
// Function
// [R1] data request answered by read reply then data packet
// [R2] bytes 0,1: command, time critical, source id, host, overtake flags
// [R3] byte 2 tag, failure, length low; byte 3 length high, nxa
// [R4] length field is doublewords minus one
// [R5] dword read copies length; byte read sends zero
// [R6] read-modify-write reply always carries length one
// [R7] failed read sets failure and still sends all data
// [R8] failure with nxa forces every data bit to one
// [R9] nxa counts only when failure is set
// [R10] time critical copied from originating request
// [R11] forwarded response keeps time critical unchanged
// [R12] host bridge returns request time critical value
// [R13] request tag copied into the response
// [R14] no-data transaction answered by target completion
// [R15] completion: bytes 0,1 shared, tag, failure, nxa only
// [R16] command entry freed when completion is issued
// [R17] each nonposted request yields exactly one response
// [R18] completion failure reports error found at target
// [R19] downstream traffic forms one stream with source id zero; downstream replies here carry I_REQ_DST as source id instead
// [R20] response channel has its own command and data buffer
// [R21] request acceptance independent of outgoing requests
// [R22] response issue independent of requests or responses
// [R23] rmw reply carries one quadword of original value
// [R24] reserved bits sent as zero and ignored
module lrp_top
(
  input  wire        I_CLK_SYS,   // system clock 25 MHz
  input  wire        I_RST_N,     // sync reset, active low
  input  wire [7:0]  I_ADDR,      // register byte address
  input  wire [31:0] I_WDATA,     // register write data
  input  wire        I_WR,        // write strobe
  input  wire        I_RD,        // read strobe
  output reg  [31:0] O_RDATA,     // read data, cycle after I_RD
  input  wire        I_REQ_VALID, // nonposted request present
  input  wire [1:0]  I_REQ_KIND,  // request kind
  input  wire [3:0]  I_REQ_LEN,   // length field of request
  input  wire [4:0]  I_REQ_TAG,   // request tag
  input  wire        I_REQ_TC,    // request time critical
  input  wire        I_REQ_PASS,  // reply may overtake posted
  input  wire        I_REQ_DOWN,  // response goes downstream
  input  wire [4:0]  I_REQ_DST,   // target id of downstream reply
  input  wire        I_REQ_FAIL,  // error found at target
  input  wire        I_REQ_NXA,   // address does not exist
  output reg         O_REQ_READY, // response slot free
  input  wire        I_DAT_WE,    // reply data buffer write
  input  wire [3:0]  I_DAT_IDX,   // doubleword index
  input  wire [31:0] I_DAT_WDATA, // doubleword
  input  wire        I_LNK_CLK,   // link clock, foreign
  output reg  [7:0]  O_LNK_DATA,  // link byte
  output reg         O_LNK_CTL,   // high on header bytes
  output reg         O_LNK_VALID, // high on any packet byte
  output reg         O_CMD_FREE   // pulse: command entry free
);
  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SEND = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [31:0] ctrl_q;
  reg  [7:0]  n_reply_q;
  reg  [7:0]  n_done_q;
  reg  [31:0] last_hdr_q;
  reg         pend_q;
  reg         is_read_q;
  reg  [3:0]  len_q;
  reg  [4:0]  tag_q;
  reg         tc_q;
  reg         pass_q;
  reg         down_q;
  reg  [4:0]  dst_q;
  reg         fail_q;
  reg         nxa_q;
  reg  [6:0]  pos_q;
  reg  [6:0]  pos_d;
  reg  [31:0] buf_q [0:`LRP_BUF_WORDS-1];
  wire        lnk_rise;
  wire [31:0] hdr;
  wire [4:0]  srcid;
  wire        host;
  wire [6:0]  total;
  wire [6:0]  dpos;
  wire [31:0] word;
  reg  [7:0]  data_byte;
  wire        accept;
  wire        enable;

  function sel;
    input [7:0] a;
    input [7:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  function [3:0] len_of;
    input [1:0] kind;
    input [3:0] req_len;
    begin
      case (kind)
        `LRP_KIND_DW_READ:   len_of = req_len;           // [R5]
        `LRP_KIND_BYTE_READ: len_of = `LRP_BYTE_COUNT;   // [R5]
        `LRP_KIND_RMW:       len_of = `LRP_RMW_COUNT;    // [R6]
        default:             len_of = 4'h0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // link clock edge detection
  // ----------------------------------------
  lrp_sync u_sync
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_async (I_LNK_CLK),
    .o_level (),
    .o_rise  (lnk_rise)
  );

  // ----------------------------------------
  // header fields
  // ----------------------------------------
  assign enable = ctrl_q[`LRP_CTRL_EN_BIT];
  // downstream replies name their target; upstream ones name us
  assign srcid = down_q ? dst_q :
                 ctrl_q[`LRP_CTRL_SRCID_LSB+4:`LRP_CTRL_SRCID_LSB]; // [R19]
  assign host  = ctrl_q[`LRP_CTRL_HOST_BIT];

  lrp_hdr u_hdr
  (
    .i_is_read (is_read_q), // [R1] [R14]
    .i_tc      (tc_q),      // [R10] [R11] [R12]
    .i_pass    (pass_q),
    .i_host    (host),
    .i_srcid   (srcid),
    .i_tag     (tag_q),     // [R13]
    .i_fail    (fail_q),    // [R7] [R18]
    .i_nxa     (nxa_q),     // [R9]
    .i_len     (len_q),     // [R4]
    .o_hdr     (hdr)        // [R2] [R3] [R15] [R24]
  );

  // ----------------------------------------
  // request slot, response channel only
  // ----------------------------------------
  // acceptance looks only at this slot, never at other channels
  assign accept = I_REQ_VALID & O_REQ_READY; // [R20] [R21]

  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      pend_q    <= 1'b0;
      is_read_q <= 1'b0;
      len_q     <= 4'h0;
      tag_q     <= 5'h00;
      tc_q      <= 1'b0;
      pass_q    <= 1'b0;
      down_q    <= 1'b0;
      dst_q     <= 5'h00;
      fail_q    <= 1'b0;
      nxa_q     <= 1'b0;
    end
    else if (accept)
    begin
      pend_q    <= 1'b1;
      is_read_q <= (I_REQ_KIND != `LRP_KIND_NO_DATA); // [R17]
      len_q     <= len_of(I_REQ_KIND, I_REQ_LEN);
      tag_q     <= I_REQ_TAG;                         // [R13]
      tc_q      <= I_REQ_TC;                          // [R10]
      pass_q    <= I_REQ_PASS;
      down_q    <= I_REQ_DOWN;
      dst_q     <= I_REQ_DST;
      fail_q    <= I_REQ_FAIL;                        // [R7] [R18]
      nxa_q     <= I_REQ_NXA & I_REQ_FAIL;            // [R9]
    end
    else if (state_q == ST_DONE)
    begin
      pend_q <= 1'b0;                                 // [R17]
    end
  end

  // ----------------------------------------
  // reply data buffer
  // ----------------------------------------
  // writes ignored while a packet is on the link, so data cannot tear
  genvar gi;
  generate
    for (gi = 0; gi < `LRP_BUF_WORDS; gi = gi + 1)
    begin : g_buf
      always @(posedge I_CLK_SYS)
      begin
        if (!I_RST_N)
        begin
          buf_q[gi] <= 32'h0000_0000;
        end
        else if (I_DAT_WE && state_q == ST_IDLE && I_DAT_IDX == gi)
        begin
          buf_q[gi] <= I_DAT_WDATA; // [R20] [R23]
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // byte selection
  // ----------------------------------------
  // full data count goes out even on failure
  assign total = is_read_q ? (`LRP_HDR_BYTES + 7'h04 + {1'b0, len_q, 2'b00})
                           : `LRP_HDR_BYTES; // [R4] [R7]
  assign dpos  = pos_q - `LRP_HDR_BYTES;
  assign word  = buf_q[dpos[5:2]];

  always @*
  begin
    data_byte = 8'h00;
    if (pos_q < `LRP_HDR_BYTES)
    begin
      case (pos_q[1:0])
        2'h0:    data_byte = hdr[7:0];
        2'h1:    data_byte = hdr[15:8];
        2'h2:    data_byte = hdr[23:16];
        default: data_byte = hdr[31:24];
      endcase
    end
    else if (fail_q && nxa_q)
    begin
      data_byte = 8'hff; // [R8]
    end
    else
    begin
      case (dpos[1:0])
        2'h0:    data_byte = word[7:0];
        2'h1:    data_byte = word[15:8];
        2'h2:    data_byte = word[23:16];
        default: data_byte = word[31:24];
      endcase
    end
  end

  // ----------------------------------------
  // transmit sequencer
  // ----------------------------------------
  // sending waits only for a link edge, nothing else
  always @*
  begin
    state_d = state_q;
    pos_d   = pos_q;
    case (state_q)
      ST_IDLE:
      begin
        pos_d = 7'h00;
        if (pend_q && lnk_rise)
        begin
          state_d = ST_SEND; // [R22]
          pos_d   = 7'h01;
        end
      end
      ST_SEND:
      begin
        if (lnk_rise)
        begin
          if (pos_q == total)
          begin
            state_d = ST_DONE;
          end
          else
          begin
            pos_d = pos_q + 7'h01;
          end
        end
      end
      ST_DONE:
      begin
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
        pos_d   = 7'h00;
      end
    endcase
  end

  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      state_q     <= ST_IDLE;
      pos_q       <= 7'h00;
      O_LNK_DATA  <= 8'h00;
      O_LNK_CTL   <= 1'b0;
      O_LNK_VALID <= 1'b0;
      O_CMD_FREE  <= 1'b0;
      O_REQ_READY <= 1'b0;
      n_reply_q   <= 8'h00;
      n_done_q    <= 8'h00;
      last_hdr_q  <= 32'h0000_0000;
    end
    else
    begin
      state_q     <= state_d;
      pos_q       <= pos_d;
      O_CMD_FREE  <= 1'b0;
      O_REQ_READY <= enable & ~pend_q & ~accept;
      if (state_q == ST_IDLE && pend_q && lnk_rise)
      begin
        O_LNK_DATA  <= hdr[7:0];
        O_LNK_CTL   <= 1'b1;
        O_LNK_VALID <= 1'b1;
        last_hdr_q  <= hdr;
        // entry released as the completion goes out
        O_CMD_FREE  <= ~is_read_q; // [R16]
        if (is_read_q)
        begin
          n_reply_q <= n_reply_q + 8'h01; // [R1]
        end
        else
        begin
          n_done_q <= n_done_q + 8'h01;   // [R14]
        end
      end
      else if (state_q == ST_SEND && lnk_rise)
      begin
        if (pos_q == total)
        begin
          O_LNK_DATA  <= 8'h00;
          O_LNK_CTL   <= 1'b0;
          O_LNK_VALID <= 1'b0;
        end
        else
        begin
          O_LNK_DATA  <= data_byte;
          O_LNK_CTL   <= (pos_q < `LRP_HDR_BYTES);
          O_LNK_VALID <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      ctrl_q  <= `LRP_CTRL_RST;
      O_RDATA <= 32'h0000_0000;
    end
    else
    begin
      if (I_WR && sel(I_ADDR, `LRP_REG_CTRL))
      begin
        ctrl_q <= I_WDATA & 32'h0000_031f;
      end
      O_RDATA <= 32'h0000_0000;
      if (I_RD)
      begin
        if (sel(I_ADDR, `LRP_REG_CTRL))
        begin
          O_RDATA <= ctrl_q;
        end
        else if (sel(I_ADDR, `LRP_REG_STATUS))
        begin
          O_RDATA <= {8'h00, n_done_q, n_reply_q,
                      5'h00, O_LNK_VALID, pend_q, ~state_q[0]};
        end
        else if (sel(I_ADDR, `LRP_REG_LAST_HDR))
        begin
          O_RDATA <= last_hdr_q;
        end
      end
    end
  end
endmodule // lrp_top

/* dv/lrp_props.sv */
// Purpose: port checks for the response packet builder
// Assumes: single clock domain, sync reset active low
// Notes:   request fields latched when a request is taken
`timescale 1ns/1ps
`include "lrp_consts.vh"
module lrp_props
(
  input wire       I_CLK_SYS,   // system clock
  input wire       I_RST_N,     // sync reset, active low
  input wire       I_REQ_VALID, // request offered
  input wire [1:0] I_REQ_KIND,  // request kind
  input wire       I_REQ_TC,    // request time critical
  input wire       O_REQ_READY, // slot free
  input wire [7:0] O_LNK_DATA,  // link byte
  input wire       O_LNK_CTL,   // header byte marker
  input wire       O_LNK_VALID, // packet byte marker
  input wire       O_CMD_FREE   // command entry freed
);
  // ----------------------------------------
  // request latch and properties
  // ----------------------------------------
  reg        tc_q;
  reg  [1:0] kind_q;
  wire       take    = I_REQ_VALID && O_REQ_READY;
  wire [5:0] cmd_exp = (kind_q == `LRP_KIND_NO_DATA) ? `LRP_CMD_TGT_DONE : `LRP_CMD_READ_REPLY;

  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      tc_q   <= 1'b0;
      kind_q <= 2'h0;
    end
    else if (take)
    begin
      tc_q   <= I_REQ_TC;
      kind_q <= I_REQ_KIND;
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  a_ready_drops: assert property (take |=> !O_REQ_READY)
    else $error("slot still free after a request was taken");
  a_reply_starts: assert property (take |-> ##[1:40] $rose(O_LNK_VALID))
    else $error("no response began after a request");
  a_first_cmd: assert property ($rose(O_LNK_VALID) |-> O_LNK_CTL && O_LNK_DATA[5:0] == cmd_exp)
    else $error("first byte has wrong command");
  a_first_tc: assert property ($rose(O_LNK_VALID) |-> O_LNK_DATA[7] == tc_q && !O_LNK_DATA[6])
    else $error("first byte time critical or reserved bit wrong");
  a_ctl_in_pkt: assert property (O_LNK_CTL |-> O_LNK_VALID)
    else $error("header marker outside a packet");
  a_ready_quiet: assert property (O_REQ_READY |-> !O_LNK_VALID)
    else $error("slot free while a packet is sent");
  a_free_pulse: assert property (O_CMD_FREE |=> !O_CMD_FREE)
    else $error("entry free longer than one cycle");
  a_free_kind: assert property (O_CMD_FREE |-> kind_q == `LRP_KIND_NO_DATA)
    else $error("entry freed for a data reply");

  c_rmw: cover property (take && I_REQ_KIND == `LRP_KIND_RMW);
  c_done: cover property (take && I_REQ_KIND == `LRP_KIND_NO_DATA);
  c_free: cover property (O_CMD_FREE);
endmodule // lrp_props

/* dv/lrp_link_partner.sv */
// Purpose: far node on the link, clock source and byte receiver
// Assumes: one byte per link rising edge
// Notes:   clock stands low between packets
`timescale 1ns/1ps
`include "lrp_consts.vh"
module lrp_link_partner
(
  input  wire        i_run,     // let the link clock toggle
  input  wire        i_valid,   // packet byte present
  input  wire [7:0]  i_data,    // link byte
  input  wire        i_ctl,     // header byte marker
  output reg         o_lnk_clk, // link clock
  output integer     o_count,   // bytes taken this packet
  output integer     o_ctl_n,   // header-marked bytes this packet
  output wire [31:0] o_expect,  // bytes the header announces
  output wire        o_nxa      // nxa as understood
);
  // ----------------------------------------
  // clock and capture
  // ----------------------------------------
  reg [7:0] cap [0:127];

  // odd offset keeps link edges away from system edges
  initial
  begin
    o_lnk_clk = 1'b0;
    o_count = 0;
    o_ctl_n = 0;
    #7;
    forever #160 o_lnk_clk = i_run ? ~o_lnk_clk : 1'b0;
  end

  always @(posedge i_run)
  begin
    o_count = 0;
    o_ctl_n = 0;
  end

  // previous byte is settled by the next link rise
  always @(posedge o_lnk_clk)
  begin
    if (i_valid && o_count < 128)
    begin
      cap[o_count] = i_data;
      o_count = o_count + 1;
      if (i_ctl)
        o_ctl_n = o_ctl_n + 1;
    end
  end

  // data follows only replies; size from length field
  assign o_expect = (cap[0][5:0] == `LRP_CMD_READ_REPLY) ?
                    32'd8 + 32'd4 * {28'h0, cap[3][1:0], cap[2][7:6]} : 32'd4;
  assign o_nxa    = cap[3][5] & cap[2][5];
endmodule // lrp_link_partner

/* dv/lrp_top_tb.sv */
// Purpose: self-checking bench of the response packet builder
// Assumes: link clock from the partner model, 320 ns period
// Notes:   reply buffer loaded once and reused by every read
`timescale 1ns/1ps
`include "lrp_consts.vh"
module lrp_top_tb;
  // ----------------------------------------
  // stimulus and checks
  // ----------------------------------------
  localparam [4:0] SRC_ID = 5'h0b;
  localparam [4:0] DST_ID = 5'h12;
  reg         clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, dat_we = 1'b0, run = 1'b0;
  reg         req_valid = 1'b0, req_tc = 1'b0, req_pass = 1'b0, req_down = 1'b0;
  reg         req_fail = 1'b0, req_nxa = 1'b0;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdata = 32'h0, dat_wdata = 32'h0, rd_val;
  reg  [1:0]  req_kind = 2'h0;
  reg  [3:0]  req_len = 4'h0, dat_idx = 4'h0;
  reg  [4:0]  req_tag = 5'h00;
  wire [31:0] rdata, p_count, p_expect, p_ctl;
  wire [7:0]  lnk_data;
  wire        req_ready, lnk_clk, lnk_ctl, lnk_valid, cmd_free, p_nxa;
  integer     errors = 0, total_checks = 0, free_seen = 0;

  always #20 clk = ~clk;
  always @(posedge clk) if (cmd_free === 1'b1) free_seen <= free_seen + 1;

  lrp_top dut_u (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_REQ_VALID(req_valid), .I_REQ_KIND(req_kind), .I_REQ_LEN(req_len),
    .I_REQ_TAG(req_tag), .I_REQ_TC(req_tc), .I_REQ_PASS(req_pass), .I_REQ_DOWN(req_down),
    .I_REQ_DST(DST_ID), .I_REQ_FAIL(req_fail), .I_REQ_NXA(req_nxa), .O_REQ_READY(req_ready),
    .I_DAT_WE(dat_we), .I_DAT_IDX(dat_idx), .I_DAT_WDATA(dat_wdata), .I_LNK_CLK(lnk_clk),
    .O_LNK_DATA(lnk_data), .O_LNK_CTL(lnk_ctl), .O_LNK_VALID(lnk_valid), .O_CMD_FREE(cmd_free));

  lrp_link_partner partner_u (.i_run(run), .i_valid(lnk_valid), .i_data(lnk_data), .i_ctl(lnk_ctl),
    .o_lnk_clk(lnk_clk), .o_count(p_count), .o_ctl_n(p_ctl), .o_expect(p_expect), .o_nxa(p_nxa));

  function [31:0] word(input integer i);
    word = 32'h3c00_0000 + i * 32'h0011_0101;
  endfunction

  task check(input string what, input [31:0] exp, input [31:0] got);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  task print_verdict;
  begin
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask

  task fail_wait;
  begin
    errors = errors + 1;
    $display("MISMATCH wait expected done seen timeout");
    print_verdict;
  end
  endtask

  task reg_wr(input [7:0] a, input [31:0] d);
  begin
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  end
  endtask

  task reg_rd(input [7:0] a);
  begin
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rd_val = rdata;
    @(posedge clk);
  end
  endtask

  task load_buf;
    integer i;
  begin
    for (i = 0; i < 16; i = i + 1)
    begin
      dat_we <= 1'b1;
      dat_idx <= i[3:0];
      dat_wdata <= word(i);
      @(posedge clk);
    end
    dat_we <= 1'b0;
    @(posedge clk);
  end
  endtask

  task send(input [1:0] k, input [3:0] ln, input [4:0] tg, input tc, input ps, input dn, input f, input nx);
    reg [3:0]  el;
    reg [31:0] hdr, w;
    reg [7:0]  eb;
    integer    i, n, cnt;
  begin
    el = (k == `LRP_KIND_DW_READ) ? ln : (k == `LRP_KIND_RMW) ? `LRP_RMW_COUNT : `LRP_BYTE_COUNT;
    hdr = {2'b00, f & nx, 3'b000, el[3:2], el[1:0], f, tg, ps, 1'b1, 1'b0, dn ? DST_ID : SRC_ID,
           tc, 1'b0, (k == `LRP_KIND_NO_DATA) ? `LRP_CMD_TGT_DONE : `LRP_CMD_READ_REPLY};
    cnt = (k == `LRP_KIND_NO_DATA) ? 4 : 8 + 4 * el;
    run <= 1'b1;
    @(posedge clk) #1;
    for (n = 0; n < 200 && req_ready !== 1'b1; n = n + 1)
      @(posedge clk) #1;
    if (n == 200) fail_wait;
    @(posedge clk);
    {req_valid, req_kind, req_len, req_tag, req_tc, req_pass} <= {1'b1, k, ln, tg, tc, ps};
    {req_down, req_fail, req_nxa} <= {dn, f, nx};
    @(posedge clk);
    req_valid <= 1'b0;
    for (n = 0; n < 100 && lnk_valid !== 1'b1; n = n + 1)
      @(posedge clk) #1;
    if (n == 100) fail_wait;
    for (n = 0; n < 1200 && lnk_valid === 1'b1; n = n + 1)
      @(posedge clk) #1;
    if (n == 1200) fail_wait;
    @(posedge clk);
    run <= 1'b0;
    // long enough for the link clock to stop, so the next packet restarts the capture
    repeat (8) @(posedge clk);
    check("byte count", cnt, p_count);
    check("header bytes", 32'd4, p_ctl);
    reg_rd(`LRP_REG_LAST_HDR);
    check("last header", hdr, rd_val);
    check("announced count", cnt, p_expect);
    check("nxa seen", {31'h0, f & nx}, {31'h0, p_nxa});
    for (i = 0; i < cnt && i < p_count; i = i + 1)
    begin
      w = word((i - 4) / 4);
      eb = (i < 4) ? hdr[8 * i +: 8] : (f & nx) ? 8'hff : w[8 * ((i - 4) % 4) +: 8];
      check("link byte", {24'h0, eb}, {24'h0, partner_u.cap[i]});
    end
  end
  endtask

  task t_regs;
  begin
    reg_wr(`LRP_REG_CTRL, 32'hffff_ffff);
    reg_rd(`LRP_REG_CTRL);
    check("ctrl mask", 32'h0000_031f, rd_val);
    reg_rd(8'h40);
    check("unmapped read", 32'h0, rd_val);
    reg_wr(`LRP_REG_CTRL, {22'h0, 1'b1, 1'b1, 3'h0, SRC_ID});
  end
  endtask

  task t_dw_read;  send(`LRP_KIND_DW_READ, 4'h2, 5'h05, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0); endtask
  task t_byte_read; send(`LRP_KIND_BYTE_READ, 4'h7, 5'h1f, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0); endtask
  task t_rmw;      send(`LRP_KIND_RMW, 4'h3, 5'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0); endtask
  task t_fail_nxa; send(`LRP_KIND_DW_READ, 4'h1, 5'h0a, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1); endtask
  task t_nxa_only; send(`LRP_KIND_DW_READ, 4'h0, 5'h0c, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1); endtask
  task t_long;     send(`LRP_KIND_DW_READ, 4'hf, 5'h15, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0); endtask

  task t_done;
    integer f0;
  begin
    f0 = free_seen;
    send(`LRP_KIND_NO_DATA, 4'hf, 5'h1e, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    check("entry frees", f0 + 1, free_seen);
  end
  endtask

  task t_status;
  begin
    reg_rd(`LRP_REG_STATUS);
    check("replies sent", 32'd6, {24'h0, rd_val[15:8]});
    check("status idle", 32'h0, {29'h0, rd_val[2:0]});
    check("completions sent", 32'd1, {24'h0, rd_val[23:16]});
  end
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    load_buf;
    t_dw_read;
    t_byte_read;
    t_rmw;
    t_fail_nxa;
    t_nxa_only;
    t_long;
    t_done;
    t_status;
    print_verdict;
  end
endmodule // lrp_top_tb

bind lrp_top lrp_props props_u (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_REQ_VALID(I_REQ_VALID),
  .I_REQ_KIND(I_REQ_KIND), .I_REQ_TC(I_REQ_TC), .O_REQ_READY(O_REQ_READY), .O_LNK_DATA(O_LNK_DATA),
  .O_LNK_CTL(O_LNK_CTL), .O_LNK_VALID(O_LNK_VALID), .O_CMD_FREE(O_CMD_FREE));
